//--- hw/tape_transport_sequencer.sv
/*
  tape transport sequencer: motion flags, settling, rewind-unload, load-point
  search, write enable, gap codes, NRZI write buffer, read skew and strobe,
  write clocks, AHB-Lite register slave.
  assumes drive pins are asynchronous and a single AHB-Lite master.
*/
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "tape_consts.svh"
module tape_transport_sequencer
  import tape_pkg::*;
#(
  parameter int CH = 7,
  parameter int unsigned SETTLE_CYC = `SETTLE_MS * (1000000 / `CLK_PERIOD_NS),
  parameter int unsigned SEARCH_CYC = `SEARCH_S * (1000000000 / `CLK_PERIOD_NS),
  parameter int unsigned SKEW_200_CYC = 3000,
  parameter int unsigned SKEW_556_CYC = 1200,
  parameter int unsigned SKEW_800_CYC = 800,
  parameter int unsigned WDLY_CYC = 100
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire drive_in_type drive_in,
  input wire logic [CH-1:0] read_pulse,
  output drive_out_type drive_out,
  output logic [CH-1:0] write_flux,
  output logic [`RL_W-1:0] read_lines
);
  localparam int unsigned REW_CYC = `REWIND_PULSE_NS / `CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYC = (`CLK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int unsigned PER_800 = 1000000000 / (`CLK_800_HZ * `CLK_PERIOD_NS);
  localparam int unsigned PER_556 = 1000000000 / (`CLK_556_HZ * `CLK_PERIOD_NS);

  drive_in_type sync1_r, din, din_d_r;
  logic [CH-1:0] rp_s1_r, rp_s2_r, rp_d_r, rp_rise;
  logic [7:0] addr_r;
  logic wr_r, hreadyout_r, hresp_r;
  logic [31:0] hrdata_r, rd_nxt;
  logic [`CMD_W-1:0] cmd_r;
  logic [CH-1:0] wdata_r, flux_r, rbuf_r, rdat_r;
  logic [`CFG_W-1:0] cfg_r;
  logic fwd_r, rev_r, we_r, unload_r, erase_r, sel_r, ready_r, motion_d_r;
  logic settling_r, settle_done_r, rew_pulse_r, false_lp_r, strobe_r;
  logic clk800_r, clk556_r, gap_on_r, skew_on_r;
  logic [31:0] settle_cnt_r, srch_cnt_r, skew_cnt_r, skew_len;
  logic [15:0] rew_cnt_r, c8_cnt_r, c5_cnt_r;
  logic [`RL_W-1:0] gap_r, rlines_r;
  search_state_type srch_r;
  logic lp_rise, rew_fall, btn_rise, clr_all, pwr_loss, mclr, motion;
  logic srch_start, srch_hit, srch_tmo, srch_end, unload_done, set_fwd;
  logic wstrobe, skew_start, skew_end, dens_any;

  // two-stage synchronisers; the second stage and a delayed copy of it (for edge detection) are looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      din <= '0;
      din_d_r <= '0;
      rp_s1_r <= '0;
      rp_s2_r <= '0;
      rp_d_r <= '0;
    end else begin
      sync1_r <= drive_in;
      din <= sync1_r;
      din_d_r <= din;
      rp_s1_r <= read_pulse;
      rp_s2_r <= rp_s1_r;
      rp_d_r <= rp_s2_r;
    end
  end

  assign lp_rise = din.load_point & ~din_d_r.load_point;
  assign rew_fall = ~din.rewinding & din_d_r.rewinding;
  assign btn_rise = din.lp_button & ~din_d_r.lp_button;
  assign rp_rise = rp_s2_r & ~rp_d_r;
  assign clr_all = ~din.auto_mode & din_d_r.auto_mode;
  assign pwr_loss = ~din.pwr_ok;
  assign mclr = cmd_r[`CMD_TERMINATE] | pwr_loss | clr_all;
  assign motion = fwd_r | rev_r;

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      hrdata_r <= 32'h0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      wr_r <= hsel & htrans[1] & hready & hwrite;
      if (hsel & htrans[1] & hready) begin
        addr_r <= haddr[7:0];
        if (!hwrite) begin
          hrdata_r <= rd_nxt;
        end
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h0;
    unique case (haddr[7:0])
      `ADDR_WDATA: rd_nxt[CH-1:0] = wdata_r;
      `ADDR_CFG: rd_nxt[`CFG_W-1:0] = cfg_r;
      `ADDR_STATUS: rd_nxt[13:0] = {gap_on_r, skew_on_r, settling_r, erase_r, din.auto_mode,
        din.rewinding, srch_r != SRCH_IDLE, false_lp_r, unload_r, rev_r, fwd_r, we_r, sel_r,
        ready_r};
      `ADDR_READ: rd_nxt[`RL_W+CH-1:0] = {rdat_r, rlines_r};
      default: rd_nxt = 32'h0;
    endcase
  end

  // command writes become one-cycle pulses; data and config are stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= '0;
      wdata_r <= '0;
      cfg_r <= '0;
    end else begin
      cmd_r <= (wr_r && addr_r == `ADDR_CMD) ? hwdata[`CMD_W-1:0] : '0;
      if (wr_r && addr_r == `ADDR_WDATA) begin
        wdata_r <= hwdata[CH-1:0];
      end
      if (wr_r && addr_r == `ADDR_CFG) begin
        cfg_r <= hwdata[`CFG_W-1:0];
      end
    end
  end

  // unit selection and gated write clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_r <= 1'b0;
      c8_cnt_r <= 16'h0;
      c5_cnt_r <= 16'h0;
      clk800_r <= 1'b0;
      clk556_r <= 1'b0;
    end else begin
      sel_r <= (cfg_r[`CFG_ADDR_LSB +: 3] == din.panel_addr) & din.auto_mode;
      c8_cnt_r <= (c8_cnt_r == 16'(PER_800 - 1)) ? 16'h0 : c8_cnt_r + 16'h1;
      c5_cnt_r <= (c5_cnt_r == 16'(PER_556 - 1)) ? 16'h0 : c5_cnt_r + 16'h1;
      clk800_r <= sel_r & (c8_cnt_r < 16'(PULSE_CYC));
      clk556_r <= sel_r & (c5_cnt_r < 16'(PULSE_CYC));
    end
  end
  a_clk_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !sel_r |=> !clk800_r && !clk556_r) else $error("write clock sent while unselected");

  // settling one-shot after motion halts or rewind ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settling_r <= 1'b0;
      settle_done_r <= 1'b0;
      settle_cnt_r <= 32'h0;
      motion_d_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      motion_d_r <= motion;
      settle_done_r <= 1'b0;
      ready_r <= ~settling_r & ~motion & ~din.rewinding;
      if (clr_all | pwr_loss) begin
        settling_r <= 1'b0;
      end else if ((motion_d_r & ~motion) | rew_fall) begin
        settling_r <= 1'b1;
        settle_cnt_r <= 32'h0;
      end else if (settling_r) begin
        if (settle_cnt_r == SETTLE_CYC - 1) begin
          settling_r <= 1'b0;
          settle_done_r <= 1'b1;
        end else begin
          settle_cnt_r <= settle_cnt_r + 32'h1;
        end
      end
    end
  end
  a_ready_after: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(settling_r) && !motion && !din.rewinding |=> ready_r)
    else $error("unit ready missing after settle");

  // rewind-unload: unload flag plus rewind pulse
  assign unload_done = unload_r & settle_done_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unload_r <= 1'b0;
      rew_pulse_r <= 1'b0;
      rew_cnt_r <= 16'h0;
    end else if (clr_all | pwr_loss) begin
      unload_r <= 1'b0;
      rew_pulse_r <= 1'b0;
    end else if (cmd_r[`CMD_REW_UNLOAD] & sel_r & ~settling_r & ~rew_pulse_r) begin
      unload_r <= 1'b1;
      rew_pulse_r <= 1'b1;
      rew_cnt_r <= 16'h0;
    end else begin
      if (unload_done) begin
        unload_r <= 1'b0;
      end
      if (rew_pulse_r) begin
        rew_cnt_r <= rew_cnt_r + 16'h1;
        if (rew_cnt_r == 16'(REW_CYC - 1)) begin
          rew_pulse_r <= 1'b0;
        end
      end
    end
  end
  a_rew_width: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rew_pulse_r) |-> unload_r && rew_cnt_r == 16'h0 ##1 rew_pulse_r [*8])
    else $error("rewind pulse short or without unload");
  a_unload_rev: assert property (@(posedge hclk) disable iff (!hresetn)
    unload_done && !mclr |=> !unload_r && rev_r) else $error("unload end did not reverse");

  // load-point search
  assign srch_start = btn_rise & (srch_r == SRCH_IDLE) & ~settling_r & ~motion;
  assign srch_hit = (srch_r == SRCH_FWD) & lp_rise;
  assign srch_tmo = (srch_r == SRCH_FWD) & ~lp_rise & (srch_cnt_r == SEARCH_CYC - 1);
  assign srch_end = ((srch_r == SRCH_REV) | (srch_r == SRCH_FAKE)) & lp_rise;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srch_r <= SRCH_IDLE;
      srch_cnt_r <= 32'h0;
      false_lp_r <= 1'b0;
    end else if (mclr) begin
      srch_r <= SRCH_IDLE;
      false_lp_r <= 1'b0;
    end else begin
      unique case (srch_r)
        SRCH_IDLE: begin
          srch_cnt_r <= 32'h0;
          if (srch_start) begin
            srch_r <= SRCH_FWD;
          end
        end
        SRCH_FWD: begin
          srch_cnt_r <= srch_cnt_r + 32'h1;
          if (srch_hit) begin
            srch_r <= SRCH_REV;
          end else if (srch_tmo) begin
            srch_r <= SRCH_FAKE;
            false_lp_r <= 1'b1;
          end
        end
        SRCH_REV, SRCH_FAKE: begin
          if (srch_end) begin
            srch_r <= SRCH_IDLE;
            false_lp_r <= 1'b0;
          end
        end
      endcase
    end
  end
  a_search_go: assert property (@(posedge hclk) disable iff (!hresetn)
    srch_start && !mclr |=> fwd_r && srch_r == SRCH_FWD) else $error("search not started");
  a_search_hit: assert property (@(posedge hclk) disable iff (!hresetn)
    srch_hit && !mclr |=> !fwd_r && rev_r && srch_r == SRCH_REV)
    else $error("search hit not reversing");
  a_search_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    srch_end && !mclr |=> !rev_r && srch_r == SRCH_IDLE) else $error("search did not halt");
  a_false_lp: assert property (@(posedge hclk) disable iff (!hresetn)
    srch_tmo && !mclr |=> false_lp_r && rev_r && !fwd_r) else $error("no false load point");

  // motion flags
  assign set_fwd = cmd_r[`CMD_SET_FWD] & sel_r & ~rev_r & ~din.rewinding & ~settling_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
    end else if (mclr) begin
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
    end else if (srch_hit | srch_tmo) begin
      fwd_r <= 1'b0;
      rev_r <= 1'b1;
    end else if (srch_end) begin
      rev_r <= 1'b0;
    end else if (unload_done) begin
      rev_r <= 1'b1;
    end else if (srch_start | set_fwd) begin
      fwd_r <= 1'b1;
    end else if (cmd_r[`CMD_HALT]) begin
      fwd_r <= 1'b0;
    end
  end
  a_settle_block: assert property (@(posedge hclk) disable iff (!hresetn)
    settling_r && !fwd_r |=> !fwd_r) else $error("motion accepted while settling");
  a_local_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_all |=> !fwd_r && !rev_r && !we_r && !unload_r && flux_r == '0)
    else $error("local mode left flags set");
  a_pwr_loss: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr_loss |=> !fwd_r && !rev_r && !we_r && !erase_r) else $error("power loss not cleared");

  // write enable, erase and gap codes on the read lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      we_r <= 1'b0;
      erase_r <= 1'b0;
      gap_on_r <= 1'b0;
      gap_r <= '0;
    end else begin
      erase_r <= we_r & ~mclr;
      if (mclr) begin
        we_r <= 1'b0;
      end else if (cmd_r[`CMD_SET_WE] & din.auto_mode & din.write_ring & sel_r) begin
        we_r <= 1'b1;
      end
      if (mclr | ~fwd_r | cmd_r[`CMD_RECORD]) begin
        gap_on_r <= 1'b0;
      end else if (cmd_r[`CMD_GAP_START]) begin
        gap_on_r <= 1'b1;
        gap_r <= `GAP_START_CODE;
      end else if (cmd_r[`CMD_GAP_STOP]) begin
        gap_on_r <= 1'b1;
        gap_r <= `GAP_STOP_CODE;
      end
    end
  end
  a_we_guard: assert property (@(posedge hclk) disable iff (!hresetn)
    !we_r && !(cmd_r[`CMD_SET_WE] && din.auto_mode && din.write_ring && sel_r) |=> !we_r)
    else $error("write enable set without its conditions");
  a_erase_write: assert property (@(posedge hclk) disable iff (!hresetn)
    erase_r |-> we_r) else $error("erase head on outside write");
  a_gap_start: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_r[`CMD_GAP_START] && fwd_r && !mclr && !cmd_r[`CMD_RECORD] |=> gap_on_r
    && gap_r == `GAP_START_CODE ##1 rlines_r == `GAP_START_CODE || !gap_on_r)
    else $error("start gap code missing");

  // write buffer: per-channel delay then flux toggle
  assign wstrobe = cmd_r[`CMD_RECORD] & sel_r & we_r;
  for (genvar i = 0; i < CH; i++) begin : g_ch
    logic wbusy_r;
    logic [15:0] wcnt_r;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        wbusy_r <= 1'b0;
        wcnt_r <= 16'h0;
        flux_r[i] <= 1'b0;
      end else if (mclr) begin
        wbusy_r <= 1'b0;
        flux_r[i] <= 1'b0;
      end else begin
        if (wstrobe & wdata_r[i]) begin
          wbusy_r <= 1'b1;
          wcnt_r <= 16'h0;
        end else if (wbusy_r) begin
          wcnt_r <= wcnt_r + 16'h1;
          if (wcnt_r == 16'(WDLY_CYC - 1)) begin
            wbusy_r <= 1'b0;
          end
        end
        if (cmd_r[`CMD_LONGITUDINAL_PARITY_CHAR]) begin
          flux_r[i] <= 1'b0;
        end else if (wbusy_r && wcnt_r == 16'(WDLY_CYC - 1)) begin
          flux_r[i] <= ~flux_r[i];
        end
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rbuf_r[i] <= 1'b0;
      end else if (rp_rise[i]) begin
        rbuf_r[i] <= 1'b1;
      end else if (skew_end | mclr) begin
        rbuf_r[i] <= 1'b0;
      end
    end
  end
  a_longitudinal_parity_char_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_r[`CMD_LONGITUDINAL_PARITY_CHAR] |=> flux_r == '0) else $error("parity character left write flags");

  // read skew one-shot, density chosen by the controller
  always_comb begin
    skew_len = SKEW_800_CYC;
    dens_any = 1'b1;
    if (cfg_r[`CFG_D200]) begin
      skew_len = SKEW_200_CYC;
    end else if (cfg_r[`CFG_D556]) begin
      skew_len = SKEW_556_CYC;
    end else if (!cfg_r[`CFG_D800]) begin
      dens_any = 1'b0;
    end
  end
  assign skew_end = skew_on_r & (skew_cnt_r == skew_len - 1);
  assign skew_start = (|rp_rise) & dens_any & (~skew_on_r | skew_end);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skew_on_r <= 1'b0;
      skew_cnt_r <= 32'h0;
      strobe_r <= 1'b0;
      rdat_r <= '0;
      rlines_r <= '0;
    end else begin
      strobe_r <= skew_end & ~mclr;
      rlines_r <= gap_on_r ? gap_r : `RL_W'(rbuf_r);
      if (skew_end) begin
        rdat_r <= rbuf_r;
      end
      if (mclr) begin
        skew_on_r <= 1'b0;
      end else if (skew_start) begin
        skew_on_r <= 1'b1;
        skew_cnt_r <= 32'h0;
      end else if (skew_end) begin
        skew_on_r <= 1'b0;
      end else if (skew_on_r) begin
        skew_cnt_r <= skew_cnt_r + 32'h1;
      end
    end
  end
  a_strobe_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    skew_end && !mclr && !(|rp_rise) |=> strobe_r && rbuf_r == '0)
    else $error("strobe and buffer clear not together");

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign write_flux = flux_r;
  assign read_lines = rlines_r;
  assign drive_out = '{forward: fwd_r, reverse: rev_r, rewind_pulse: rew_pulse_r,
    false_lp: false_lp_r, unload: unload_r, unit_ready: ready_r, sel_remote: sel_r,
    write_permit: we_r, erase: erase_r, clk_800: clk800_r, clk_556: clk556_r,
    char_strobe: strobe_r};
endmodule : tape_transport_sequencer

//--- pkg/tape_consts.svh
/*
  named constants of the tape transport sequencer: register offsets,
  command and configuration field positions, gap codes and timing figures.
  assumes the includer wants plain `define names.
*/
`ifndef TAPE_CONSTS_SVH
`define TAPE_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define SETTLE_MS 5
`define REWIND_PULSE_NS 12000
`define SEARCH_S 4
`define CLK_PULSE_NS 400
`define CLK_800_HZ 60000
`define CLK_556_HZ 41700
`define ADDR_CMD 8'h00
`define ADDR_WDATA 8'h04
`define ADDR_CFG 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_READ 8'h10
`define CMD_SET_WE 0
`define CMD_SET_FWD 1
`define CMD_GAP_START 2
`define CMD_GAP_STOP 3
`define CMD_RECORD 4
`define CMD_TERMINATE 5
`define CMD_REW_UNLOAD 6
`define CMD_LONGITUDINAL_PARITY_CHAR 7
`define CMD_HALT 8
`define CMD_W 9
`define CFG_ADDR_LSB 0
`define CFG_D200 4
`define CFG_D556 5
`define CFG_D800 6
`define CFG_W 8
`define GAP_START_CODE 9'h010
`define GAP_STOP_CODE 9'h140
`define RL_W 9
`endif

//--- pkg/tape_pkg.sv
/*
  types of the tape transport sequencer: drive pin groups and the
  load-point search states. widths are written out here, not taken from tape_consts.svh.
*/
package tape_pkg;
  typedef struct packed {
    logic pwr_ok;
    logic auto_mode;
    logic write_ring;
    logic load_point;
    logic rewinding;
    logic lp_button;
    logic [2:0] panel_addr;
  } drive_in_type;
  typedef struct packed {
    logic forward;
    logic reverse;
    logic rewind_pulse;
    logic false_lp;
    logic unload;
    logic unit_ready;
    logic sel_remote;
    logic write_permit;
    logic erase;
    logic clk_800;
    logic clk_556;
    logic char_strobe;
  } drive_out_type;
  typedef enum logic [1:0] {SRCH_IDLE, SRCH_FWD, SRCH_REV, SRCH_FAKE} search_state_type;
endpackage : tape_pkg

//--- sim/drive_model.sv
/*
  behavioural drive electronics: rewinds on the rewind pulse and stops at
  load point, gives load-point marks on request, reads back flux reversals.
  assumes one clock and the sequencer's drive_out and write_flux ports.
*/
`timescale 1ns/10ps
module drive_model
  import tape_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire drive_out_type dout,
  input wire logic [6:0] flux,
  input wire logic lp_req,
  output logic rewinding,
  output logic load_point,
  output logic [6:0] read_pulse
);
  logic rp_q;
  logic [10:0] rw_cnt;
  logic [2:0] lp_cnt;
  logic [2:0] rd_cnt;
  logic [6:0] flux_q;
  logic [6:0] rd_mask;
  assign load_point = lp_cnt != 3'h0;
  assign read_pulse = (rd_cnt != 3'h0) ? rd_mask : 7'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rp_q <= 1'b0;
      rewinding <= 1'b0;
      rw_cnt <= '0;
      lp_cnt <= '0;
      rd_cnt <= '0;
      flux_q <= '0;
      rd_mask <= '0;
    end else begin
      rp_q <= dout.rewind_pulse;
      flux_q <= flux;
      if (dout.rewind_pulse && !rp_q) begin
        rewinding <= 1'b1;
        rw_cnt <= 11'h5dc;
      end else if (rw_cnt != 11'h0) begin
        rw_cnt <= rw_cnt - 11'h1;
      end else begin
        rewinding <= 1'b0;
      end
      if (lp_req || (rewinding && rw_cnt == 11'h0)) begin
        lp_cnt <= 3'h4;
      end else if (lp_cnt != 3'h0) begin
        lp_cnt <= lp_cnt - 3'h1;
      end
      if (flux != flux_q) begin
        rd_mask <= flux ^ flux_q;
        rd_cnt <= 3'h4;
      end else if (rd_cnt != 3'h0) begin
        rd_cnt <= rd_cnt - 3'h1;
      end
    end
  end
endmodule : drive_model

//--- sim/tape_transport_sequencer_test.sv
/*
  testbench of the tape transport sequencer: AHB-Lite register tasks,
  write, read-after-write, gap codes, rewind-unload, search and power loss.
  assumes drive_model as the drive and shortened settle, search and skew counts.
*/
`timescale 1ns/10ps
`include "tape_consts.svh"
module tape_transport_sequencer_test
  import tape_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lp_req = 0;
  logic pwr = 0, auto = 0, ring = 0, btn = 0;
  logic [2:0] pan = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic hreadyout, hresp, rewinding, load_point;
  logic [6:0] read_pulse, write_flux;
  logic [8:0] read_lines;
  drive_in_type din;
  drive_out_type dout;
  int err_total = 0, cmp_count = 0, cyc = 0, strobes = 0, rwp_len = 0, n = 0, m = 0;
  always #5 hclk = ~hclk;
  assign din = {pwr, auto, ring, load_point, rewinding, btn, pan};
  tape_transport_sequencer #(.SETTLE_CYC(20), .SEARCH_CYC(50), .SKEW_200_CYC(20),
    .SKEW_556_CYC(10), .SKEW_800_CYC(8)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .drive_in(din), .read_pulse(read_pulse),
    .drive_out(dout), .write_flux(write_flux), .read_lines(read_lines));
  drive_model pm (.hclk(hclk), .hresetn(hresetn), .dout(dout), .flux(write_flux),
    .lp_req(lp_req), .rewinding(rewinding), .load_point(load_point),
    .read_pulse(read_pulse));
  task results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task cmd(input int n);
    bus(1'b1, `ADDR_CMD, 32'h1 << n);
    wt(3);
  endtask : cmd
  task lpp;
    lp_req <= 1'b1;
    wt(1);
    lp_req <= 1'b0;
    wt(8);
  endtask : lpp
  task rec(input logic [6:0] d, input logic [6:0] f);
    bus(1'b1, `ADDR_WDATA, {25'h0, d});
    cmd(`CMD_RECORD);
    wt(140);
    chk("flux", 32'(f), 32'(write_flux));
    bus(1'b0, `ADDR_READ, 32'h0);
    chk("char", 32'(d), 32'(q[15:9]));
    chk("rbuf", 32'h0, 32'(q[8:0]));
  endtask : rec
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (dout.char_strobe === 1'b1) strobes <= strobes + 1;
    if (dout.rewind_pulse === 1'b1) rwp_len <= rwp_len + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      results();
    end
  end
  initial begin
    wt(3);
    chk("reset out", 32'h0, 32'(dout));
    chk("reset bus", 32'h1, 32'({hresp, hreadyout}));
    wt(1);
    hresetn <= 1'b1;
    pwr <= 1'b1;
    ring <= 1'b1;
    pan <= 3'h3;
    bus(1'b1, `ADDR_CFG, 32'h43);
    cmd(`CMD_SET_WE);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk("we no auto", 32'h0, q & 32'h4);
    chk("no clk", 32'h0, 32'({dout.clk_800, dout.clk_556}));
    auto <= 1'b1;
    wt(6);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk("selected", 32'h2, q & 32'h2);
    for (int i = 0; i < 2000 && dout.clk_800 !== 1'b0; i++) wt(1);
    for (int i = 0; i < 2000 && dout.clk_800 !== 1'b1; i++) wt(1);
    for (n = 0; n < 2000 && dout.clk_800 === 1'b1; n++) wt(1);
    chk("clk800 width", 32'(`CLK_PULSE_NS / `CLK_PERIOD_NS), 32'(n));
    for (m = n; m < 4000 && dout.clk_800 !== 1'b1; m++) wt(1);
    chk("clk800 period", 32'(1000000000 / (`CLK_800_HZ * `CLK_PERIOD_NS)), 32'(m));
    for (int i = 0; i < 3000 && dout.clk_556 !== 1'b0; i++) wt(1);
    for (int i = 0; i < 3000 && dout.clk_556 !== 1'b1; i++) wt(1);
    for (n = 0; n < 2000 && dout.clk_556 === 1'b1; n++) wt(1);
    chk("clk556 width", 32'(`CLK_PULSE_NS / `CLK_PERIOD_NS), 32'(n));
    cmd(`CMD_SET_WE);
    cmd(`CMD_SET_FWD);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk("writing", 32'h40c, q & 32'h40c);
    cmd(`CMD_GAP_START);
    bus(1'b0, `ADDR_READ, 32'h0);
    chk("gap start", 32'(`GAP_START_CODE), q & 32'h1ff);
    rec(7'h55, 7'h55);
    rec(7'h0f, 7'h5a);
    chk("strobes", 32'h2, 32'(strobes));
    bus(1'b1, `ADDR_CFG, 32'h23);
    rec(7'h01, 7'h5b);
    chk("strobes 556", 32'h3, 32'(strobes));
    bus(1'b1, `ADDR_CFG, 32'h03);
    bus(1'b1, `ADDR_WDATA, 32'h01);
    cmd(`CMD_RECORD);
    wt(140);
    chk("flux none", 32'h5a, 32'(write_flux));
    chk("strobes none", 32'h3, 32'(strobes));
    cmd(`CMD_LONGITUDINAL_PARITY_CHAR);
    wt(40);
    chk("longitudinal_parity_char", 32'h0, 32'(write_flux));
    cmd(`CMD_GAP_STOP);
    bus(1'b0, `ADDR_READ, 32'h0);
    chk("gap stop", 32'(`GAP_STOP_CODE), q & 32'h1ff);
    cmd(`CMD_TERMINATE);
    cmd(`CMD_SET_FWD);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk("stopped", 32'h800, q & 32'hc0c);
    wt(25);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk("unit ready", 32'h1, q & 32'h801);
    cmd(`CMD_REW_UNLOAD);
    chk("unload", 32'h3, 32'({dout.unload, dout.rewind_pulse}));
    for (int i = 0; i < 3000 && dout.reverse !== 1'b1; i++) wt(1);
    chk("pulse len", 32'd1200, 32'(rwp_len));
    chk("unloaded", 32'h1, 32'({dout.unload, dout.reverse}));
    auto <= 1'b0;
    wt(6);
    chk("local", 32'h0, 32'({dout.forward, dout.reverse, dout.write_permit}));
    auto <= 1'b1;
    wt(30);
    btn <= 1'b1;
    wt(6);
    chk("search fwd", 32'h1, 32'(dout.forward));
    btn <= 1'b0;
    lpp();
    chk("search rev", 32'h1, 32'({dout.forward, dout.reverse}));
    lpp();
    chk("search halt", 32'h0, 32'(dout.reverse));
    wt(25);
    btn <= 1'b1;
    wt(6);
    btn <= 1'b0;
    wt(60);
    chk("fake lp", 32'h3, 32'({dout.false_lp, dout.reverse}));
    lpp();
    chk("real lp", 32'h0, 32'({dout.false_lp, dout.reverse}));
    wt(25);
    cmd(`CMD_SET_WE);
    cmd(`CMD_SET_FWD);
    chk("rearm", 32'h3, 32'({dout.forward, dout.write_permit}));
    pwr <= 1'b0;
    wt(6);
    chk("power loss", 32'h0, 32'({dout.forward, dout.write_permit}));
    results();
  end
endmodule : tape_transport_sequencer_test
